// >>> verilog/cpgrd_top.sv
// Call-progress monitor gain stage, ring delay timer and their registers
`timescale 1ns/1ns
module cpgrd_top
	import cpgrd_pkg::*;
#(
	parameter int unsigned MS_CYCLES = CYC_PER_MS
)
(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rstn,
	// Register port
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic [7:0]                      reg_rdata,
	// Monitor samples
	input  wire logic signed [SAMPLE_W-1:0] rx_monitor_in,
	input  wire logic signed [SAMPLE_W-1:0] tx_monitor_in,
	input  wire logic                       monitor_valid,
	// Monitor output
	output logic signed [SAMPLE_W-1:0]      call_progress_monitor_out,
	output logic                            call_progress_monitor_valid,
	// Ring validation
	input  wire logic                       ring_validated,
	output logic                            ring_valid,
	output logic [DELAY_CODE_W-1:0]         ring_delay_code,
	output logic [MARGIN_MSB:0]             ring_period_margin
);

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);
	localparam logic [SUM_W-1:0] SAT_MAX  = SUM_W'((1 << (SAMPLE_W - 1)) - 1);
	localparam logic [SUM_W-1:0] SAT_MIN  = SUM_W'(-(1 << (SAMPLE_W - 1)));

	cpgrd_regs_t regs;
	cpgrd_regs_t next_regs;

	cpgrd_ring_state_t ring_state;
	cpgrd_ring_state_t next_ring_state;

	logic                      sat_flag;
	logic                      scaled_valid;
	logic [DIV_W-1:0]          ms_div;
	logic [MS_CNT_W-1:0]       ms_elapsed;

	// Register decode
	wire logic                 wr_rx_gain;
	wire logic                 wr_tx_gain;
	wire logic                 wr_ring_one;
	wire logic                 wr_ring_two;
	wire logic                 wr_status;
	wire logic [7:0]           status_word;
	wire logic [7:0]           next_rdata;

	// Gain data path
	wire logic signed [SCALED_W-1:0] rx_scaled;
	wire logic signed [SCALED_W-1:0] tx_scaled;
	wire logic signed [SUM_W-1:0]    sum;
	wire logic                       sum_high;
	wire logic                       sum_low;
	wire logic signed [SAMPLE_W-1:0] next_monitor;

	// Ring delay
	wire logic [MS_CNT_W-1:0]  delay_target;
	wire logic                 delay_zero;
	wire logic                 delay_done;
	wire logic                 ms_tick;
	wire logic                 next_ring_valid;
	wire logic                 next_sat_flag;

	assign wr_rx_gain  = reg_wr && (reg_addr == ADDR_RX_GAIN);
	assign wr_tx_gain  = reg_wr && (reg_addr == ADDR_TX_GAIN);
	assign wr_ring_one = reg_wr && (reg_addr == ADDR_RING_ONE);
	assign wr_ring_two = reg_wr && (reg_addr == ADDR_RING_TWO);
	assign wr_status   = reg_wr && (reg_addr == ADDR_STATUS);

	assign next_regs.rx_gain       = wr_rx_gain  ? reg_wdata : regs.rx_gain;
	assign next_regs.tx_gain       = wr_tx_gain  ? reg_wdata : regs.tx_gain;
	assign next_regs.ring_ctrl_one = wr_ring_one ? reg_wdata : regs.ring_ctrl_one;
	assign next_regs.delay_top     = wr_ring_two ? reg_wdata[DELAY_TOP_BIT] : regs.delay_top;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			regs.rx_gain       <= RX_GAIN_RST;
			regs.tx_gain       <= TX_GAIN_RST;
			regs.ring_ctrl_one <= RING_ONE_RST;
			regs.delay_top     <= DELAY_TOP_RST;
		end else begin
			regs <= next_regs;
		end
	end

	assign status_word = {5'h00,
		sat_flag,
		(ring_state == RING_WAIT),
		ring_valid};

	// Unmapped addresses read as zero
	assign next_rdata =
		!reg_rd                       ? 8'h00 :
		(reg_addr == ADDR_RX_GAIN)    ? regs.rx_gain :
		(reg_addr == ADDR_TX_GAIN)    ? regs.tx_gain :
		(reg_addr == ADDR_RING_ONE)   ? regs.ring_ctrl_one :
		(reg_addr == ADDR_RING_TWO)   ? {regs.delay_top, 7'h00} :
		(reg_addr == ADDR_STATUS)     ? status_word :
		8'h00;

	// Read data stand for exactly the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// Each path has its own instance of the same scaling module so their rounding matches
	cpgrd_scale u_rx_scale (
		.clk          (clk),
		.rstn         (rstn),
		.sample_in    (rx_monitor_in),
		.sample_valid (monitor_valid),
		.gain_code    (regs.rx_gain),
		.scaled       (rx_scaled)
	);

	cpgrd_scale u_tx_scale (
		.clk          (clk),
		.rstn         (rstn),
		.sample_in    (tx_monitor_in),
		.sample_valid (monitor_valid),
		.gain_code    (regs.tx_gain),
		.scaled       (tx_scaled)
	);

	// One extra bit keeps the sum exact before clipping
	assign sum      = SUM_W'(rx_scaled) + SUM_W'(tx_scaled);
	assign sum_high = (sum > $signed(SAT_MAX));
	assign sum_low  = (sum < $signed(SAT_MIN));
	assign next_monitor =
		sum_high ? SAMPLE_W'(SAT_MAX) :
		sum_low  ? SAMPLE_W'(SAT_MIN) :
		sum[SAMPLE_W-1:0];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			scaled_valid <= 1'b0;
		end else begin
			scaled_valid <= monitor_valid;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			call_progress_monitor_out   <= '0;
			call_progress_monitor_valid <= 1'b0;
		end else begin
			call_progress_monitor_valid <= scaled_valid;
			if (scaled_valid) begin
				call_progress_monitor_out <= next_monitor;
			end
		end
	end

	// Sticky clip flag; a clip in the clearing cycle keeps it set
	assign next_sat_flag = (scaled_valid && (sum_high || sum_low)) ||
		(sat_flag && !(wr_status && reg_wdata[STAT_SAT_BIT]));

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sat_flag <= 1'b0;
		end else begin
			sat_flag <= next_sat_flag;
		end
	end

	// Ring delay code and timing
	assign ring_delay_code = {regs.delay_top,
		regs.ring_ctrl_one[DELAY_LO_MSB:DELAY_LO_LSB]};
	assign ring_period_margin = regs.ring_ctrl_one[MARGIN_MSB:0];

	// Each code step adds 256 ms, so the target is the code shifted up
	assign delay_target = MS_CNT_W'(ring_delay_code) *
		MS_CNT_W'(RING_STEP_MS);
	assign delay_zero   = (ring_delay_code == '0);
	assign delay_done   = (ms_elapsed >= delay_target);
	assign ms_tick      = (ring_state == RING_WAIT) && (ms_div == DIV_LAST);

	always_comb begin
		next_ring_state = ring_state;
		unique case (ring_state)
			RING_IDLE: begin
				if (ring_validated) begin
					next_ring_state = delay_zero ? RING_VALID : RING_WAIT;
				end
			end
			RING_WAIT: begin
				if (!ring_validated) begin
					next_ring_state = RING_IDLE;
				end else if (delay_done) begin
					next_ring_state = RING_VALID;
				end
			end
			RING_VALID: begin
				if (!ring_validated) begin
					next_ring_state = RING_IDLE;
				end
			end
			default: begin
				next_ring_state = RING_IDLE;
			end
		endcase
	end

	assign next_ring_valid = (next_ring_state == RING_VALID);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ring_state <= RING_IDLE;
			ring_valid <= 1'b0;
		end else begin
			ring_state <= next_ring_state;
			ring_valid <= next_ring_valid;
		end
	end

	// Millisecond divider runs only while waiting, so every wait starts at zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ms_div     <= '0;
			ms_elapsed <= '0;
		end else if (ring_state != RING_WAIT) begin
			ms_div     <= '0;
			ms_elapsed <= '0;
		end else if (ms_tick) begin
			ms_div     <= '0;
			ms_elapsed <= ms_elapsed + MS_CNT_W'(1);
		end else begin
			ms_div     <= ms_div + DIV_W'(1);
		end
	end

endmodule

// >>> verilog/cpgrd_pkg.sv
// Constants, types and register map of the call-progress gain and ring delay block
package cpgrd_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_RX_GAIN   = 8'h14;
	localparam logic [7:0] ADDR_TX_GAIN   = 8'h15;
	localparam logic [7:0] ADDR_RING_ONE  = 8'h16;
	localparam logic [7:0] ADDR_RING_TWO  = 8'h17;
	localparam logic [7:0] ADDR_STATUS    = 8'h18;

	// Reset values
	localparam logic [7:0] RX_GAIN_RST    = 8'h00;
	localparam logic [7:0] TX_GAIN_RST    = 8'h00;
	localparam logic [7:0] RING_ONE_RST   = 8'h96;
	localparam logic       DELAY_TOP_RST  = 1'b0;

	// Field positions
	localparam int DELAY_LO_MSB     = 7;
	localparam int DELAY_LO_LSB     = 6;
	localparam int MARGIN_MSB       = 5;
	localparam int DELAY_TOP_BIT    = 7;
	localparam int STAT_VALID_BIT   = 0;
	localparam int STAT_WAIT_BIT    = 1;
	localparam int STAT_SAT_BIT     = 2;

	// Data path widths
	localparam int SAMPLE_W         = 16;
	localparam int GAIN_W           = 8;
	localparam int GAIN_SHIFT       = 6;
	localparam int SCALED_W         = 18;
	localparam int SUM_W            = SCALED_W + 1;
	localparam int DELAY_CODE_W     = 3;

	// Timing: delay steps of 256 ms, counted in 1 ms ticks
	localparam int CLK_PERIOD_NS    = 8;
	localparam int MS_IN_NS         = 1000000;
	localparam int CYC_PER_MS       = MS_IN_NS / CLK_PERIOD_NS;
	localparam int RING_STEP_MS     = 256;
	localparam int MS_CNT_W         = 11;
	localparam int DIV_W            = 17;

	typedef struct packed {
		logic [GAIN_W-1:0] rx_gain;
		logic [GAIN_W-1:0] tx_gain;
		logic [7:0]        ring_ctrl_one;
		logic              delay_top;
	} cpgrd_regs_t;

	typedef enum logic [1:0] {
		RING_IDLE  = 2'b00,
		RING_WAIT  = 2'b01,
		RING_VALID = 2'b10
	} cpgrd_ring_state_t;

endpackage

// >>> verilog/cpgrd_scale.sv
// One monitor path: sample times gain code over 64, registered
`timescale 1ns/1ns
module cpgrd_scale
	import cpgrd_pkg::*;
(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rstn,
	// Sample and gain
	input  wire logic signed [SAMPLE_W-1:0] sample_in,
	input  wire logic                       sample_valid,
	input  wire logic [GAIN_W-1:0]          gain_code,
	// Scaled result
	output logic signed [SCALED_W-1:0]      scaled
);

	localparam int PROD_W = SAMPLE_W + GAIN_W + 1;

	wire logic signed [PROD_W-1:0]   product;
	wire logic                       muted;
	wire logic signed [SCALED_W-1:0] next_scaled;

	// Gain code is unsigned, so it gets a zero sign bit before the signed multiply
	assign product     = sample_in * $signed({1'b0, gain_code});
	assign muted       = (gain_code == '0);
	// Arithmetic shift by six divides by 64; flooring keeps it cheap
	assign next_scaled = muted ? '0 : product[GAIN_SHIFT +: SCALED_W];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			scaled <= '0;
		end else if (sample_valid) begin
			scaled <= next_scaled;
		end
	end

endmodule

// >>> sim/cpgrd_chk.sv
// Port assertions for the monitor gain stage and ring delay timer
`timescale 1ns/1ns
module cpgrd_chk
	import cpgrd_pkg::*;
#(
	parameter int unsigned MS_CYCLES = CYC_PER_MS
)
(
	// Clock and reset
	input wire logic			clk,
	input wire logic			rstn,
	// Register port
	input wire logic [7:0]			reg_addr,
	input wire logic [7:0]			reg_wdata,
	input wire logic			reg_wr,
	input wire logic			reg_rd,
	input wire logic [7:0]			reg_rdata,
	// Monitor path
	input wire logic signed [SAMPLE_W-1:0]	rx_monitor_in,
	input wire logic signed [SAMPLE_W-1:0]	tx_monitor_in,
	input wire logic			monitor_valid,
	input wire logic signed [SAMPLE_W-1:0]	call_progress_monitor_out,
	input wire logic			call_progress_monitor_valid,
	// Ring delay
	input wire logic			ring_validated,
	input wire logic			ring_valid,
	input wire logic [DELAY_CODE_W-1:0]	ring_delay_code,
	input wire logic [MARGIN_MSB:0]		ring_period_margin
);
	// Shadows rebuilt from writes only, so a stuck register in the design shows up
	logic [7:0]	rx_g;
	logic [7:0]	tx_g;
	logic [7:0]	ring1;
	logic		msb;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rx_g <= RX_GAIN_RST;
			tx_g <= TX_GAIN_RST;
			ring1 <= RING_ONE_RST;
			msb <= DELAY_TOP_RST;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_RX_GAIN) rx_g <= reg_wdata;
			if (reg_addr == ADDR_TX_GAIN) tx_g <= reg_wdata;
			if (reg_addr == ADDR_RING_ONE) ring1 <= reg_wdata;
			if (reg_addr == ADDR_RING_TWO) msb <= reg_wdata[7];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_result;
		##2 call_progress_monitor_valid;
	endsequence
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_mon_latency: assert property (monitor_valid |-> s_result)
		else $error("monitor result not two cycles after sample");
	a_mute_both: assert property (monitor_valid && rx_g == 8'h00 && tx_g == 8'h00 |->
		s_result ##0 call_progress_monitor_out == 16'sh0000) else $error("muted paths leak");
	a_unity_rx: assert property (monitor_valid && rx_g == 8'h40 && tx_g == 8'h00 |->
		s_result ##0 call_progress_monitor_out == $past(rx_monitor_in, 2)) else $error("rx unity");
	a_unity_tx: assert property (monitor_valid && tx_g == 8'h40 && rx_g == 8'h00 |->
		s_result ##0 call_progress_monitor_out == $past(tx_monitor_in, 2)) else $error("tx unity");
	a_sum_no_wrap: assert property (monitor_valid && !rx_monitor_in[15] && !tx_monitor_in[15]
		|-> ##2 !call_progress_monitor_out[15]) else $error("positive sum wrapped");
	a_delay_code: assert property ({ring_delay_code, ring_period_margin} == {msb, ring1})
		else $error("ring delay code not from registers");
	a_no_delay: assert property ($rose(ring_validated) && ring_delay_code == 3'h0
		|-> ##[1:2] ring_valid) else $error("code zero ring late");
	a_delay_hold: assert property ($rose(ring_validated) && ring_delay_code != 3'h0
		|=> !ring_valid [*8]) else $error("ring valid before delay");
endmodule

// >>> sim/cpgrd_bench.sv
// Self-checking bench for the monitor gain stage and ring delay timer
`timescale 1ns/1ns
module cpgrd_bench
	import cpgrd_pkg::*;
;
	logic			clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic			monitor_valid = 1'b0, ring_validated = 1'b0, mon_vld, ring_valid;
	logic [7:0]		reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic signed [15:0]	rx_in = 16'h0000, tx_in = 16'h0000, mon_out;
	logic [2:0]		delay_code;
	logic [5:0]		margin;
	int			errors = 0, n_tests = 0, i;
	always #4 clk = ~clk;
	// Short millisecond so a one-step delay is 1024 cycles
	cpgrd_top #(.MS_CYCLES(4)) u_cpgrd_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_monitor_in(rx_in), .tx_monitor_in(tx_in), .monitor_valid(monitor_valid),
		.call_progress_monitor_out(mon_out), .call_progress_monitor_valid(mon_vld),
		.ring_validated(ring_validated), .ring_valid(ring_valid),
		.ring_delay_code(delay_code), .ring_period_margin(margin));
	task chk(input string name, input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk) reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, exp);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk) reg_rd <= 1'b0;
		#1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
	endtask
	task mon(input logic [15:0] rx, tx, exp);
		@(posedge clk) {monitor_valid, rx_in, tx_in} <= {1'b1, rx, tx};
		@(posedge clk) monitor_valid <= 1'b0;
		// The valid pulse stands only in the second cycle after the strobe
		@(posedge clk);
		#1 chk("monitor_valid", {15'h0000, mon_vld}, 16'h0001);
		chk("monitor_out", mon_out, exp);
	endtask
	task t_reset;
		rd(ADDR_RX_GAIN, 8'h00);
		rd(ADDR_TX_GAIN, 8'h00);
		rd(ADDR_RING_ONE, 8'h96);
		rd(8'h30, 8'h00);
		chk("ring_delay_code", {13'h0000, delay_code}, 16'h0002);
		chk("ring_period_margin", {10'h000, margin}, 16'h0016);
	endtask
	task t_gain;
		mon(16'h03E8, 16'h01F4, 16'h0000);
		wr(ADDR_RX_GAIN, 8'h40);
		mon(16'h03E8, 16'h01F4, 16'h03E8);
		wr(ADDR_RX_GAIN, 8'h00);
		wr(ADDR_TX_GAIN, 8'h40);
		mon(16'h03E8, 16'hFE0C, 16'hFE0C);
	endtask
	task t_sat;
		wr(ADDR_RX_GAIN, 8'hFF);
		wr(ADDR_TX_GAIN, 8'h7F);
		rd(ADDR_RX_GAIN, 8'hFF);
		mon(16'h03E8, 16'hFFC0, 16'h0F11);
		mon(16'h7FFF, 16'h7FFF, 16'h7FFF);
		mon(16'h8000, 16'h8000, 16'h8000);
		rd(ADDR_STATUS, 8'h04);
		wr(ADDR_STATUS, 8'h04);
		rd(ADDR_STATUS, 8'h00);
	endtask
	task t_ring_zero;
		wr(ADDR_RING_ONE, 8'h2A);
		#1 chk("ring_period_margin", {10'h000, margin}, 16'h002A);
		chk("ring_delay_code", {13'h0000, delay_code}, 16'h0000);
		@(posedge clk) ring_validated <= 1'b1;
		@(posedge clk);
		#1 chk("ring_valid", {15'h0000, ring_valid}, 16'h0001);
		rd(ADDR_STATUS, 8'h01);
		@(posedge clk) ring_validated <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("ring_valid", {15'h0000, ring_valid}, 16'h0000);
	endtask
	task t_ring_delay;
		wr(ADDR_RING_ONE, 8'h56);
		wr(ADDR_RING_TWO, 8'h80);
		#1 chk("ring_delay_code", {13'h0000, delay_code}, 16'h0005);
		rd(ADDR_RING_TWO, 8'h80);
		wr(ADDR_RING_TWO, 8'h00);
		@(posedge clk) ring_validated <= 1'b1;
		repeat (1000) @(posedge clk);
		#1 chk("ring_valid", {15'h0000, ring_valid}, 16'h0000);
		rd(ADDR_STATUS, 8'h02);
		for (i = 0; i < 60 && ring_valid !== 1'b1; i++) @(posedge clk) #1;
		// One 256 ms step of 4-cycle milliseconds ends near cycle 1026
		chk("ring_wait", {15'h0000, i >= 20 && i <= 32}, 16'h0001);
		@(posedge clk) ring_validated <= 1'b0;
	endtask
	task report_and_stop;
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		report_and_stop;
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_gain;
		t_sat;
		t_ring_zero;
		t_ring_delay;
		report_and_stop;
	end
endmodule
bind cpgrd_top cpgrd_chk #(.MS_CYCLES(MS_CYCLES)) u_cpgrd_chk (.clk(clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .rx_monitor_in(rx_monitor_in), .tx_monitor_in(tx_monitor_in),
	.monitor_valid(monitor_valid), .call_progress_monitor_out(call_progress_monitor_out),
	.call_progress_monitor_valid(call_progress_monitor_valid), .ring_valid(ring_valid),
	.ring_validated(ring_validated), .ring_delay_code(ring_delay_code),
	.ring_period_margin(ring_period_margin));
